// >>> rtl/ps_config_consts.svh
// timing constants for the passive serial configuration sequencer
`ifndef PS_CONFIG_CONSTS_SVH
`define PS_CONFIG_CONSTS_SVH

`define SYS_CLK_MHZ 100
`define REQ_TO_LOW_NS 800
`define REQ_TO_LOW_CYC ((`REQ_TO_LOW_NS * `SYS_CLK_MHZ) / 1000)
`define STATUS_LOW_MIN_US 10
`define STATUS_LOW_MIN_CYC (`STATUS_LOW_MIN_US * `SYS_CLK_MHZ)
`define STATUS_LOW_MAX_US 40
`define STATUS_LOW_MAX_CYC (`STATUS_LOW_MAX_US * `SYS_CLK_MHZ)
`define STARTUP_MIN_US 18
`define STARTUP_MIN_CYC (`STARTUP_MIN_US * `SYS_CLK_MHZ)
`define STARTUP_MAX_US 40
`define STARTUP_MAX_CYC (`STARTUP_MAX_US * `SYS_CLK_MHZ)
`define USR_ENABLE_PERIODS 4
`define CFG_CLK_MAX_PERIOD_NS 10
`define USR_ENABLE_CYC ((`USR_ENABLE_PERIODS * `CFG_CLK_MAX_PERIOD_NS * `SYS_CLK_MHZ) / 1000)
`define USR_STARTUP_CYCLES 299
`define POR_MS 100
// kept in whole milliseconds so the product stays inside a 32-bit int
`define POR_CYC (`POR_MS * 1000 * `SYS_CLK_MHZ)
`define LOAD_BITS_DEFAULT 1024

`endif

// >>> rtl/ps_config_pkg.sv
// types shared by the passive serial configuration sequencer
package ps_config_pkg;
  typedef enum logic [5:0] {
    ST_POR     = 6'h01,
    ST_RESET   = 6'h02,
    ST_WAIT_HI = 6'h04,
    ST_LOAD    = 6'h08,
    ST_INIT    = 6'h10,
    ST_USER    = 6'h20
  } cfg_state_e;
endpackage

// >>> rtl/ps_config_sequencer.sv
// passive serial configuration sequencer: reset, load and start-up stages
`include "ps_config_consts.svh"

// Summary of operation
// R01 - request low pulls load-done low within 800 ns
// R02 - request low pulls status low within 800 ns
// R03 - host holds request low at least 2 us
// R04 - own status low pulse lasts 10 to 40 us unless stretched
// R05 - request high releases status within 40 us
// R06 - host waits 40 us after request high before first clock
// R07 - host waits 1 us after status high before first clock
// R08 - host keeps config clock at or below 100 MHz
// R09 - oscillator start-up enters user mode 18 to 40 us after load-done
// R10 - user start-up clock accepted four max clock periods after load-done
// R11 - user mode 299 user clock periods after that clock is enabled
// R12 - host keeps supplying user start-up clock after last bit
// R13 - in user mode request, status and load-done stay high
// R14 - request low in user mode starts reconfiguration
// R15 - status held low through the power-on delay
// R16 - load-done low from power-up until configuration completes
// R17 - host holds config clock steady in user mode
// R18 - host drives the data input to a fixed level afterwards
// R19 - each data bit captured on rising config clock edge
// R20 - load-done released after complete error-free data
// R21 - error pulls status low, resets, auto-restart releases within 40 us
// R22 - device in reset while request or status is low; status low is not acted on in init or user mode
// R23 - host restarts with a request pulse on status low during load
module ps_config_sequencer
  import ps_config_pkg::*;
#(
  parameter int POR_CYCLES = `POR_CYC,
  parameter int LOAD_BITS = `LOAD_BITS_DEFAULT
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // option straps
  input wire logic use_user_startup_clock,
  input wire logic auto_restart,
  // configuration pins
  input wire logic config_request_n,
  input wire logic config_status_n_in,
  output logic config_status_n_out,
  output logic config_status_n_oe,
  input wire logic load_done_in,
  output logic load_done_out,
  output logic load_done_oe,
  // link clocks and data
  input wire logic config_clock,
  input wire logic config_serial_data_in,
  input wire logic user_startup_clock,
  // state
  output logic user_mode
);
  cfg_state_e state_reg;
  cfg_state_e state_next;
  logic [1:0] req_sync_reg;
  logic [1:0] stat_sync_reg;
  logic [1:0] done_sync_reg;
  logic [1:0] tog_sync_reg;
  logic [1:0] usr_sync_reg;
  logic [1:0] err_sync_reg;
  logic [1:0] usr_strap_sync_reg;
  logic [1:0] restart_strap_sync_reg;
  logic [31:0] load_count_reg;
  logic tog_seen_reg;
  logic [31:0] timer_reg;
  logic load_enable_reg;
  logic usr_enable_reg;
  logic error_reg;
  logic status_low_reg;
  logic done_low_reg;
  logic opt_usr_reg;
  logic opt_restart_reg;
  logic link_toggle;
  logic link_error;
  logic link_usr_done;
  logic bit_event;
  logic req_low;
  logic stat_low;
  logic load_complete;

  ps_link_shifter link_u (
    .config_clock(config_clock),
    .config_serial_data_in(config_serial_data_in),
    .user_startup_clock(user_startup_clock),
    .load_enable(load_enable_reg),
    .usr_count_enable(usr_enable_reg),
    .bit_toggle(link_toggle),
    .bit_count(),
    .crc_error(link_error),
    .usr_done(link_usr_done)
  );

  // ******************************
  // pin, strap and link-result synchronisers
  // ******************************
  always_ff @(posedge sys_clk) begin
    req_sync_reg <= {req_sync_reg[0], config_request_n};
    stat_sync_reg <= {stat_sync_reg[0], config_status_n_in};
    done_sync_reg <= {done_sync_reg[0], load_done_in};
    tog_sync_reg <= {tog_sync_reg[0], link_toggle};
    usr_sync_reg <= {usr_sync_reg[0], link_usr_done};
    err_sync_reg <= {err_sync_reg[0], link_error};
    usr_strap_sync_reg <= {usr_strap_sync_reg[0], use_user_startup_clock};
    restart_strap_sync_reg <= {restart_strap_sync_reg[0], auto_restart};
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tog_seen_reg <= 1'b0;
    end else begin
      tog_seen_reg <= tog_sync_reg[1];
    end
  end

  assign bit_event = tog_seen_reg != tog_sync_reg[1];
  assign req_low = !req_sync_reg[1];
  assign stat_low = !stat_sync_reg[1];
  // bits are counted here from the toggle events rather than by reading the link-side
  // word, which may be mid-change when sampled on this clock
  assign load_complete = bit_event && (load_count_reg == 32'(LOAD_BITS - 1));

  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != ST_LOAD) begin
      load_count_reg <= 32'h0;
    end else if (bit_event) begin
      load_count_reg <= load_count_reg + 32'h1; // R19
    end
  end

  // straps are sampled through the power-on delay and held from its end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opt_usr_reg <= 1'b0;
      opt_restart_reg <= 1'b0;
    end else if (state_reg == ST_POR) begin
      opt_usr_reg <= usr_strap_sync_reg[1];
      opt_restart_reg <= restart_strap_sync_reg[1];
    end
  end

  // ******************************
  // sequencer
  // ******************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR: begin
        if (timer_reg >= 32'(POR_CYCLES - 1)) begin
          state_next = ST_RESET; // R15
        end
      end
      ST_RESET: begin
        // own pulse ends after the minimum; request low stretches it
        if (!req_low && timer_reg >= 32'(`STATUS_LOW_MIN_CYC - 1)) begin
          state_next = ST_WAIT_HI; // R04 R05
        end
      end
      ST_WAIT_HI: begin
        if (req_low) begin
          state_next = ST_RESET; // R22
        end else if (!stat_low) begin
          state_next = ST_LOAD; // R22
        end
      end
      ST_LOAD: begin
        if (req_low || error_reg || stat_low) begin
          state_next = ST_RESET; // R21 R22
        end else if (load_complete) begin
          state_next = ST_INIT; // R20
        end
      end
      ST_INIT: begin
        if (req_low) begin
          state_next = ST_RESET;
        end else if (opt_usr_reg ? usr_sync_reg[1]
                                 : (timer_reg >= 32'(`STARTUP_MIN_CYC - 1))) begin
          state_next = ST_USER; // R09 R11
        end
      end
      ST_USER: begin
        if (req_low) begin
          state_next = ST_RESET; // R14
        end
      end
      default: state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || state_next != state_reg) begin
      timer_reg <= 32'h0;
    end else if (timer_reg != 32'hFFFFFFFF) begin
      timer_reg <= timer_reg + 32'h1;
    end
  end

  // error latched while loading; without auto-restart status stays low until a request pulse
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      error_reg <= 1'b0;
    end else if (state_reg == ST_LOAD && err_sync_reg[1]) begin
      error_reg <= 1'b1; // R21
    end else if (req_low || (opt_restart_reg && state_reg == ST_RESET)) begin
      error_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      load_enable_reg <= 1'b0;
      usr_enable_reg <= 1'b0;
    end else begin
      load_enable_reg <= (state_next == ST_LOAD); // R19
      // enable the user clock once four maximum config periods have passed
      usr_enable_reg <= opt_usr_reg && state_reg == ST_INIT
                        && timer_reg >= 32'(`USR_ENABLE_CYC - 1); // R10
    end
  end

  // ******************************
  // pin drive
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_low_reg <= 1'b1;
      done_low_reg <= 1'b1;
    end else begin
      // driving two cycles after the synchronised request keeps well inside 800 ns
      status_low_reg <= req_low || state_next == ST_POR || state_next == ST_RESET
                        || (error_reg && !opt_restart_reg); // R02 R15 R21
      done_low_reg <= req_low || (state_next != ST_INIT && state_next != ST_USER); // R01 R16 R20
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_status_n_out <= 1'b0;
      config_status_n_oe <= 1'b1;
      load_done_out <= 1'b0;
      load_done_oe <= 1'b1;
      user_mode <= 1'b0;
    end else begin
      config_status_n_out <= 1'b0;
      config_status_n_oe <= status_low_reg;
      load_done_out <= 1'b0;
      load_done_oe <= done_low_reg; // R13
      user_mode <= (state_reg == ST_USER); // R13
    end
  end
endmodule

// >>> rtl/ps_link_shifter.sv
// link-side logic on the configuration and user start-up clocks: bit capture and user start-up counting
module ps_link_shifter (
  // configuration clock domain
  input wire logic config_clock,
  input wire logic config_serial_data_in,
  // user start-up clock domain
  input wire logic user_startup_clock,
  // control from the system domain, levels
  input wire logic load_enable,
  input wire logic usr_count_enable,
  // results back to the system domain
  output logic bit_toggle,
  output logic [31:0] bit_count,
  output logic crc_error,
  output logic usr_done
);
  `include "ps_config_consts.svh"

  logic [1:0] usr_en_sync_reg;
  logic [8:0] usr_count_reg;
  logic [31:0] parity_reg;

  // ******************************
  // capture on config clock
  // ******************************
  // the host parks the link clock whenever the enable moves (it waits after status
  // rises and stops at the frame end), so the enable clears this side directly;
  // a synchroniser here would never be flushed by a stopped clock
  always_ff @(posedge config_clock or negedge load_enable) begin
    if (!load_enable) begin
      bit_count <= 32'h0;
      parity_reg <= 32'h0;
      bit_toggle <= 1'b0;
      crc_error <= 1'b0;
    end else begin
      bit_count <= bit_count + 32'h1; // R19
      parity_reg <= {parity_reg[30:0], parity_reg[31] ^ config_serial_data_in}; // R19
      bit_toggle <= ~bit_toggle;
      // stuck-high stream counts as an error; registered so the crossing sees no glitch
      crc_error <= (parity_reg == 32'hFFFFFFFF); // R21
    end
  end

  // ******************************
  // user start-up clock counting
  // ******************************
  // this clock may already run when the enable rises, so release passes two flops
  always_ff @(posedge user_startup_clock or negedge usr_count_enable) begin
    if (!usr_count_enable) begin
      usr_en_sync_reg <= 2'h0;
    end else begin
      usr_en_sync_reg <= {usr_en_sync_reg[0], 1'b1};
    end
  end

  // the two release periods and the edge that sets done are part of the span, so the count stops three short
  always_ff @(posedge user_startup_clock or negedge usr_count_enable) begin
    if (!usr_count_enable) begin
      usr_count_reg <= 9'h000;
      usr_done <= 1'b0;
    end else if (!usr_en_sync_reg[1]) begin
      usr_count_reg <= 9'h000;
    end else if (usr_count_reg != 9'(`USR_STARTUP_CYCLES - 3)) begin
      usr_count_reg <= usr_count_reg + 9'h001; // R11
    end else begin
      usr_done <= 1'b1; // R11
    end
  end
endmodule

// >>> verif/passive_serial_config_sequencer_tb.sv
// self-checking bench for the passive serial configuration sequencer
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module passive_serial_config_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, reset, use_user_startup_clock, auto_restart;
  logic config_request_n, config_clock, config_serial_data_in, user_startup_clock;
  logic config_status_n_out, config_status_n_oe, load_done_out, load_done_oe, user_mode;
  logic status_line, done_line;
  int n_errors, n_checks;
  // open-drain lines with pull-ups
  assign status_line = config_status_n_oe ? config_status_n_out : 1'b1;
  assign done_line = load_done_oe ? load_done_out : 1'b1;
  ps_config_sequencer #(.POR_CYCLES(100), .LOAD_BITS(16)) ps_config_sequencer_i (
    .sys_clk(sys_clk), .reset(reset), .use_user_startup_clock(use_user_startup_clock),
    .auto_restart(auto_restart), .config_request_n(config_request_n),
    .config_status_n_in(status_line), .config_status_n_out(config_status_n_out),
    .config_status_n_oe(config_status_n_oe), .load_done_in(done_line),
    .load_done_out(load_done_out), .load_done_oe(load_done_oe), .config_clock(config_clock),
    .config_serial_data_in(config_serial_data_in), .user_startup_clock(user_startup_clock),
    .user_mode(user_mode));
  ps_host_model ps_host_model_i (
    .sys_clk(sys_clk), .config_status_n(status_line), .config_request_n(config_request_n),
    .config_clock(config_clock), .config_serial_data_in(config_serial_data_in),
    .user_startup_clock(user_startup_clock));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // counted from reset release: 100 cycle power-on delay, then the own pulse
  task automatic power_up();
    int n;
    repeat (50) @(negedge sys_clk);
    `CHK("status_por", 1'b0, status_line)
    `CHK("done_por", 1'b0, done_line)
    n = 50;
    while (status_line !== 1'b1 && n < 6000) begin @(negedge sys_clk); n++; end
    `CHK("status_pulse", 1'b1, n >= 1100 && n <= 4110)
  endtask
  task automatic load_osc();
    int n;
    ps_host_model_i.load(15, 1'b1);
    repeat (20) @(negedge sys_clk);
    `CHK("done_early", 1'b0, done_line)
    ps_host_model_i.load(1, 1'b0);
    n = 0;
    while (done_line !== 1'b1 && n < 20) begin @(negedge sys_clk); n++; end
    `CHK("done_up", 1'b1, done_line)
    n = 0;
    while (user_mode !== 1'b1 && n < 5000) begin @(negedge sys_clk); n++; end
    `CHK("startup_span", 1'b1, n >= 1795 && n <= 4000)
    `CHK("user_status", 1'b1, status_line)
    `CHK("user_done", 1'b1, done_line)
  endtask
  task automatic reconfig();
    int n;
    fork ps_host_model_i.request_pulse(); join_none
    repeat (81) @(negedge sys_clk);
    `CHK("done_low", 1'b0, done_line)
    `CHK("status_low", 1'b0, status_line)
    `CHK("user_left", 1'b0, user_mode)
    while (config_request_n !== 1'b1) @(negedge sys_clk);
    n = 0;
    while (status_line !== 1'b1 && n < 4100) begin @(negedge sys_clk); n++; end
    `CHK("status_release", 1'b1, n <= 4005)
  endtask
  // second run from a fresh reset with the user start-up clock strap set
  task automatic load_user_clock();
    reset = 1'b1;
    use_user_startup_clock = 1'b1;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    power_up();
    ps_host_model_i.load(16, 1'b1);
    repeat (8000) @(negedge sys_clk);
    `CHK("no_user_clock", 1'b0, user_mode)
    ps_host_model_i.usr_clocks(298);
    repeat (20) @(negedge sys_clk);
    `CHK("usr_298", 1'b0, user_mode)
    ps_host_model_i.usr_clocks(4);
    repeat (20) @(negedge sys_clk);
    `CHK("usr_enough", 1'b1, user_mode)
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    n_errors = 0;
    n_checks = 0;
    reset = 1'b1;
    use_user_startup_clock = 1'b0;
    auto_restart = 1'b1;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    power_up();
    load_osc();
    reconfig();
    load_user_clock();
    print_verdict();
  end
  // whole run is near 220 us; over four times that means a hang
  initial begin
    #1ms;
    n_errors++;
    print_verdict();
  end
endmodule

// >>> verif/ps_config_sequencer_assertions.sv
// concurrent checks on the configuration sequencer pins
module ps_config_sequencer_assertions #(
  parameter int POR_CYCLES = 100,
  parameter int LOAD_BITS = 16
) (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // straps
  input wire logic use_user_startup_clock,
  input wire logic auto_restart,
  // configuration pins
  input wire logic config_request_n,
  input wire logic config_status_n_in,
  input wire logic config_status_n_out,
  input wire logic config_status_n_oe,
  input wire logic load_done_in,
  input wire logic load_done_out,
  input wire logic load_done_oe,
  // link
  input wire logic config_clock,
  input wire logic config_serial_data_in,
  input wire logic user_startup_clock,
  // state
  input wire logic user_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // saturating counters keep long spans out of the property engine
  logic [15:0] lo_cnt_reg;
  logic [15:0] hi_cnt_reg;
  logic [15:0] rel_cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (reset || !config_status_n_oe) lo_cnt_reg <= 16'h0000;
    else if (lo_cnt_reg != 16'hFFFF) lo_cnt_reg <= lo_cnt_reg + 16'h0001;
  end
  // a held request stretches the pulse, so the span restarts while it is low
  always_ff @(posedge sys_clk) begin
    if (reset || !config_request_n || !config_status_n_oe) hi_cnt_reg <= 16'h0000;
    else if (hi_cnt_reg != 16'hFFFF) hi_cnt_reg <= hi_cnt_reg + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (reset || load_done_oe) rel_cnt_reg <= 16'h0000;
    else if (rel_cnt_reg != 16'hFFFF) rel_cnt_reg <= rel_cnt_reg + 16'h0001;
  end
  done_on_request_a: assert property ($fell(config_request_n) |-> ##[1:80] load_done_oe)
    else $error("load-done not pulled low after request");
  status_on_request_a: assert property ($fell(config_request_n) |-> ##[1:80] config_status_n_oe)
    else $error("status not pulled low after request");
  user_lines_high_a: assert property (user_mode |-> !config_status_n_oe && !load_done_oe)
    else $error("pin pulled low in user mode");
  held_in_reset_a: assert property ((!config_request_n || !config_status_n_in) [*8] |-> !user_mode && load_done_oe)
    else $error("device not in reset while request or status low");
  status_pulse_min_a: assert property ($fell(config_status_n_oe) |-> lo_cnt_reg >= 16'h03E8)
    else $error("status pulse shorter than 10 us");
  status_release_a: assert property (int'(hi_cnt_reg) <= POR_CYCLES + 4008)
    else $error("status not released within 40 us");
  osc_startup_a: assert property ($rose(user_mode) && !use_user_startup_clock |->
    rel_cnt_reg >= 16'h0708 && rel_cnt_reg <= 16'h0FA0)
    else $error("start-up outside 18 to 40 us");
  done_release_a: assert property ($fell(load_done_oe) |-> config_request_n && config_status_n_in && !user_mode)
    else $error("load-done released during reset");
  cover property ($rose(user_mode));
  cover property ($fell(config_status_n_oe));
  cover property ($fell(load_done_oe));
endmodule

bind ps_config_sequencer ps_config_sequencer_assertions #(
  .POR_CYCLES(POR_CYCLES),
  .LOAD_BITS(LOAD_BITS)
) ps_config_sequencer_assertions_i (
  .sys_clk(sys_clk), .reset(reset), .use_user_startup_clock(use_user_startup_clock),
  .auto_restart(auto_restart), .config_request_n(config_request_n),
  .config_status_n_in(config_status_n_in), .config_status_n_out(config_status_n_out),
  .config_status_n_oe(config_status_n_oe), .load_done_in(load_done_in),
  .load_done_out(load_done_out), .load_done_oe(load_done_oe), .config_clock(config_clock),
  .config_serial_data_in(config_serial_data_in), .user_startup_clock(user_startup_clock),
  .user_mode(user_mode)
);

// >>> verif/ps_host_model.sv
// host model driving the request, serial data and start-up clock pins
module ps_host_model (
  // observed
  input wire logic sys_clk,
  input wire logic config_status_n,
  // driven
  output logic config_request_n,
  output logic config_clock,
  output logic config_serial_data_in,
  output logic user_startup_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    config_request_n = 1'b1;
    config_clock = 1'b0;
    config_serial_data_in = 1'b0;
    user_startup_clock = 1'b0;
  end
  // a 2 us low pulse starts a fresh cycle, also the way out of an error
  task automatic request_pulse();
    @(negedge sys_clk);
    config_request_n = 1'b0;
    repeat (200) @(negedge sys_clk);
    config_request_n = 1'b1;
  endtask
  // 30 ns clock, parked low between frames; alternating data avoids the error pattern
  task automatic load(input int n, input bit fresh);
    int w;
    w = 0;
    while (fresh && config_status_n !== 1'b1 && w < 6000) begin
      @(negedge sys_clk);
      w++;
    end
    if (fresh) #40us;
    for (int i = 0; i < n; i++) begin
      config_serial_data_in = i[0];
      #7 config_clock = 1'b1;
      #15 config_clock = 1'b0;
      #8;
    end
    config_serial_data_in = 1'b1;
  endtask
  task automatic usr_clocks(input int n);
    repeat (n) begin
      #15 user_startup_clock = 1'b1;
      #15 user_startup_clock = 1'b0;
    end
  endtask
endmodule
